//--- pioa_pkg.sv
// constants for the port a parallel i/o block
package pioa_pkg;
  // -----------------------------------------------------------------
  // register map (byte addresses)
  // -----------------------------------------------------------------
  localparam logic [11:0] PIOA_OFF_DATA = 12'h000;
  localparam logic [11:0] PIOA_OFF_DIR = 12'h004;
  localparam int PIOA_WIDTH = 8;
  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [7:0] PIOA_DIR_RESET = 8'h00;
  localparam logic [7:0] PIOA_SYNC_RESET = 8'h00;
  localparam logic [31:0] PIOA_RDATA_RESET = 32'h0000_0000;
  localparam logic PIOA_READY_RESET = 1'b0;
  localparam logic PIOA_ERR_RESET = 1'b0;
  // -----------------------------------------------------------------
  // bus states
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    PIOA_IDLE = 2'b01,
    PIOA_DONE = 2'b10
  } pioa_state_t;
endpackage

//--- pioa_port.sv
// port a: eight-pin bidirectional i/o with apb registers
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R1 - eight pins, each independently an input or an output
// R2 - one data latch per pin; reset does not change it
// R3 - direction one drives latch onto pin; zero leaves pin undriven
// R4 - reset clears all direction bits, every pin starts as input
// R5 - reading data returns latch for pins set as outputs
// R6 - reading data returns sampled pin level for pins set as inputs
// R7 - data writes always update latches; input pins unaffected
// R8 - software should load latch before turning a pin to output
// R9 - direction register reads back the value last written
// R10 - pin levels pass a two-stage synchroniser before being read
module pioa_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe
);
  // -----------------------------------------------------------------
  // address decode helper
  // -----------------------------------------------------------------
  // shared by both register selects
  function automatic logic pioa_hit(
    input logic [11:0] addr,
    input logic [11:0] offset
  );
    pioa_hit = (addr == offset);
  endfunction

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic [7:0] port_a_data_latch;
  logic [7:0] port_a_direction;
  logic [7:0] pin_sync;
  logic [7:0] read_mux;
  pioa_pkg::pioa_state_t state;
  pioa_pkg::pioa_state_t next_state;

  // -----------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------
  logic hit_data;
  logic hit_dir;
  logic hit_any;
  logic setup_phase;
  logic load_resp;
  logic access_done;
  logic wr_data_en;
  logic wr_dir_en;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;

  assign hit_data = pioa_hit(paddr, pioa_pkg::PIOA_OFF_DATA);
  assign hit_dir = pioa_hit(paddr, pioa_pkg::PIOA_OFF_DIR);
  assign hit_any = hit_data | hit_dir;
  assign setup_phase = psel & ~penable;
  assign load_resp = setup_phase & (state == pioa_pkg::PIOA_IDLE);
  assign access_done = psel & penable & pready;

  // only byte lane 0 carries register bits; upper lanes are ignored
  assign wr_data_en = access_done & pwrite & pstrb[0] & hit_data;
  assign wr_dir_en = access_done & pwrite & pstrb[0] & hit_dir;

  // unmapped offsets answer with an error, nothing is written
  assign next_pslverr = load_resp & ~hit_any;

  // -----------------------------------------------------------------
  // pin input synchroniser
  // -----------------------------------------------------------------
  // pins are asynchronous to pclk; two stages before any read
  pioa_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .async_in(pin_in),
    .sync_out(pin_sync)
  ); // [R10]

  // -----------------------------------------------------------------
  // per-pin read selection
  // -----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < pioa_pkg::PIOA_WIDTH; gi++) begin : g_pin
      // each pin chooses on its own direction bit [R1]
      assign read_mux[gi] = port_a_direction[gi] ?
        port_a_data_latch[gi] : // [R5]
        pin_sync[gi]; // [R6]
    end
  endgenerate

  assign next_prdata = hit_data ? {24'h00_0000, read_mux} :
    hit_dir ? {24'h00_0000, port_a_direction} : // [R9]
    pioa_pkg::PIOA_RDATA_RESET;

  // -----------------------------------------------------------------
  // bus response state machine
  // -----------------------------------------------------------------
  // one wait-free access phase: ready follows every setup cycle
  always_comb begin
    next_state = state;
    next_pready = 1'b0;
    case (state)
      pioa_pkg::PIOA_IDLE: begin
        if (setup_phase) begin
          next_state = pioa_pkg::PIOA_DONE;
          next_pready = 1'b1;
        end
      end
      pioa_pkg::PIOA_DONE: begin
        next_state = pioa_pkg::PIOA_IDLE;
      end
      default: begin
        next_state = pioa_pkg::PIOA_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= pioa_pkg::PIOA_IDLE;
      pready <= pioa_pkg::PIOA_READY_RESET;
      pslverr <= pioa_pkg::PIOA_ERR_RESET;
    end else if (clk_en) begin
      state <= next_state;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // read data is captured at setup so it stands through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= pioa_pkg::PIOA_RDATA_RESET;
    end else if (clk_en && load_resp) begin
      prdata <= next_prdata;
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_direction <= pioa_pkg::PIOA_DIR_RESET; // [R4]
    end else if (clk_en && wr_dir_en) begin
      port_a_direction <= pwdata[7:0]; // [R9]
    end
  end

  // no reset on purpose: the latch survives a system reset, so its
  // value is unknown after power-up until software writes it
  always_ff @(posedge pclk) begin
    if (clk_en && wr_data_en) begin
      port_a_data_latch <= pwdata[7:0]; // [R2] [R7]
    end
  end

  // -----------------------------------------------------------------
  // pin drive
  // -----------------------------------------------------------------
  // the latch always reaches the pad; only the enable decides
  assign pin_out = port_a_data_latch; // [R3]
  assign pin_oe = port_a_direction; // [R3]

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  sequence s_read_data_setup;
    load_resp && !pwrite && hit_data && clk_en;
  endsequence

  sequence s_dir_write;
    wr_dir_en && clk_en;
  endsequence

  sequence s_latch_write;
    wr_data_en && clk_en;
  endsequence

  sequence s_sync_run;
    clk_en ##1 clk_en;
  endsequence

  property p_dir_reset;
    @(posedge pclk) !presetn |-> port_a_direction == pioa_pkg::PIOA_DIR_RESET;
  endproperty

  property p_dir_write;
    @(posedge pclk) disable iff (!presetn)
    s_dir_write |=> port_a_direction == $past(pwdata[7:0]);
  endproperty

  property p_latch_write;
    @(posedge pclk) disable iff (!presetn)
    s_latch_write |=> port_a_data_latch == $past(pwdata[7:0]);
  endproperty

  property p_read_outputs;
    @(posedge pclk) disable iff (!presetn)
    s_read_data_setup |=> ((prdata[7:0] & $past(port_a_direction)) ==
      ($past(port_a_data_latch) & $past(port_a_direction)));
  endproperty

  property p_read_inputs;
    @(posedge pclk) disable iff (!presetn)
    s_read_data_setup |=> ((prdata[7:0] & ~$past(port_a_direction)) ==
      ($past(pin_sync) & ~$past(port_a_direction)));
  endproperty

  property p_sync_two_stage;
    @(posedge pclk) disable iff (!presetn)
    s_sync_run |=> pin_sync == $past(pin_in, 2);
  endproperty

  a_dir_reset_clear: assert property (p_dir_reset) // [R4]
    else $error("direction not cleared during reset");

  a_dir_write_lands: assert property (p_dir_write) // [R9]
    else $error("direction write did not land");

  a_latch_write_lands: assert property (p_latch_write) // [R7]
    else $error("data latch write did not land");

  a_read_outputs: assert property (p_read_outputs) // [R5]
    else $error("output pin read did not return its latch");

  a_read_inputs: assert property (p_read_inputs) // [R6]
    else $error("input pin read did not return the pin level");

  a_sync_two_stage: assert property (p_sync_two_stage) // [R10]
    else $error("pin level did not pass exactly two stages");
endmodule
`default_nettype wire

//--- pioa_sync.sv
// two flip-flop synchroniser for the pin inputs
`timescale 1ns/1ns
`default_nettype none
module pioa_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [7:0] async_in,
  output logic [7:0] sync_out
);
  logic [7:0] meta;

  // meta feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= pioa_pkg::PIOA_SYNC_RESET;
      sync_out <= pioa_pkg::PIOA_SYNC_RESET;
    end else if (clk_en) begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

//--- tb_top.sv
// testbench for the port a block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
logic pclk=0, psel=0, penable=0, pwrite=0;
logic presetn, err;
logic [11:0] paddr=12'h000;
logic [31:0] pwdata=32'h0, prdata, rd;
logic pready, pslverr;
logic [7:0] pin_in=8'h3c, pin_out, pin_oe;
int error_cnt=0, checks_done=0, cyc=0;
initial forever #4 pclk=~pclk;
pioa_port dut(.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .pin_in,
  .pin_out, .pin_oe);
task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
  @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
  @(posedge pclk) penable <= 1'b1;
  do @(posedge pclk); while (pready !== 1'b1);
  rd = prdata;
  err = pslverr;
  {psel, penable} <= 2'b00;
endtask
task chk(input string n, input logic [31:0] s, input logic [31:0] e);
  checks_done++;
  if (s !== e) begin
    error_cnt++;
    $display("CHECK FAILED %s exp %h got %h", n, e, s);
  end
endtask
task report_and_stop;
  $display("checks %0d mismatches %0d", checks_done, error_cnt);
  if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
  else $display("Checks failed");
  $finish;
endtask
// watchdog: past 2000 cycles, count a failure and stop the run
always @(posedge pclk) if (++cyc > 2000) begin
  error_cnt++;
  report_and_stop;
end
initial begin
  presetn <= 1'b0;
  repeat (4) @(posedge pclk);
  presetn <= 1'b1;
  acc(0, 12'h004, 0); chk("dir", rd, 32'h0);
  chk("oe", pin_oe, 8'h00);
  acc(1, 12'h000, 32'ha5);
  acc(1, 12'h004, 32'h0f);
  @(posedge pclk);
  chk("oe", pin_oe, 8'h0f);
  chk("out", pin_out & 8'h0f, 8'h05);
  repeat (3) @(posedge pclk);
  acc(0, 12'h000, 0); chk("data", rd, 32'h35);
  acc(1, 12'h000, 32'h5a);
  acc(0, 12'h000, 0); chk("data", rd, 32'h3a);
  acc(0, 12'h004, 0); chk("dir", rd, 32'h0f);
  acc(0, 12'h008, 0); chk("err", err, 32'h1);
  $display("register tests done");
  presetn <= 1'b0;
  repeat (2) @(posedge pclk);
  presetn <= 1'b1;
  acc(0, 12'h004, 0); chk("dir2", rd, 32'h0);
  acc(1, 12'h004, 32'hff);
  acc(0, 12'h000, 0); chk("latch", rd, 32'h5a);
  $display("port tests done");
  report_and_stop;
end
endmodule
`default_nettype wire
